// ===== bench/bsc_ctl_model.sv
// Board-level scan controller model that drives the test port
`timescale 1ns/100ps
module bsc_ctl_model (
   input wire logic i_tdo,
   input wire logic i_tdo_oe_n,
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   output logic o_trst_n
);
   logic oe_bad;
   logic oe_seen;
   initial begin
      o_tck = 1'h0;
      o_tms = 1'h1;
      o_tdi = 1'h1;
      o_trst_n = 1'h0;
      oe_bad = 1'h0;
      oe_seen = 1'h1;
   end
   ////////////////////////////////////////////////////////////////
   // One 12 ns test clock cycle; the clock rests low between frames
   task automatic step(input logic m, input logic b, output logic q);
      #1 o_tms = m;
      o_tdi = b;
      #5 q = i_tdo;
      oe_seen = i_tdo_oe_n;
      o_tck = 1'h1;
      #6 o_tck = 1'h0;
   endtask
   task automatic trst();
      logic q;
      o_trst_n = 1'h0;
      step(1'h1, 1'h1, q);
      #1 o_trst_n = 1'h1;
      step(1'h0, 1'h1, q);
   endtask
   task automatic tlr();
      logic q;
      repeat (5) step(1'h1, 1'h1, q);
      step(1'h0, 1'h1, q);
   endtask
   // Scan from Idle back to Idle, LSB first
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'h1, 1'h1, q);
      if (ir) step(1'h1, 1'h1, q);
      step(1'h0, 1'h1, q);
      step(1'h0, 1'h1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         if (oe_seen !== 1'h0) oe_bad = 1'h1;
         dout[i] = q;
      end
      step(1'h1, 1'h1, q);
      step(1'h0, 1'h1, q);
   endtask
endmodule

// ===== bench/bsc_tap_top_bench.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
module bsc_tap_top_bench import bsc_pkg::*;;
   logic clk, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe_n, test_act;
   logic [1:0] pad_in, core_in, core_out, out_pin, out_oe_n, bidi_pin, bidi_ext, bidi_o, bidi_oe_n;
   logic [1:0] cb_out, cb_oe, cb_in;
   logic [31:0] d;
   logic [7:0] e;
   int n_fail = 0;
   int total_checks = 0;
   localparam logic [7:0] PRE = 8'hD6;
   localparam logic [7:0] NEWV = 8'h6B;
   // Pad level: the design wins where it drives, else the board level
   assign bidi_pin = (~bidi_oe_n & bidi_o) | (bidi_oe_n & bidi_ext);
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   bsc_tap_top bsc_tap_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_scan_clk(tck), .i_scan_rst_n(trst_n),
      .i_scan_mode_sel(tms), .i_scan_data_in(tdi), .o_scan_data_out(tdo), .o_scan_data_out_oe_n(tdo_oe_n),
      .i_pad_in(pad_in), .o_core_in(core_in), .i_core_out(core_out), .o_out_pin(out_pin),
      .o_out_pin_oe_n(out_oe_n), .i_bidi_pin(bidi_pin), .o_bidi_pin(bidi_o), .o_bidi_pin_oe_n(bidi_oe_n),
      .i_core_bidi_out(cb_out), .i_core_bidi_oe(cb_oe), .o_core_bidi_in(cb_in), .o_core_test_active(test_act));
   bsc_ctl_model bsc_ctl_model_inst (.i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
      .o_trst_n(trst_n));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Only assigned opcodes are issued
   task automatic ir(input logic [IR_W-1:0] op);
      bsc_ctl_model_inst.scan(1'h1, 6, {26'h0, op}, d);
      chk(d[5:0], IR_CAPTURE_IR_DEFAULT);
   endtask
   task automatic dr(input int n, input logic [31:0] din);
      bsc_ctl_model_inst.scan(1'h0, n, din, d);
   endtask
   function automatic logic [7:0] cap(input logic ext);
      logic [1:0] bd;
      bd = ext ? bidi_pin : (cb_oe & cb_out) | (~cb_oe & bidi_pin);
      return {bd[1], cb_oe[1], bd[0], cb_oe[0], core_out, pad_in};
   endfunction
   task automatic pins(input logic [7:0] p);
      chk(out_pin, p[3:2]);
      chk(out_oe_n, 2'h0);
      chk(bidi_oe_n, {~p[6], ~p[4]});
      chk(bidi_o & ~bidi_oe_n, {p[7], p[5]} & {p[6], p[4]});
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      bsc_ctl_model_inst.trst();
      dr(32, 32'h0);
      chk(d, ID_VALUE);
   endtask
   task automatic t_bypass();
      ir(IR_BYPASS);
      dr(2, 32'h3);
      chk(d[1:0], 2'h2);
      chk(out_pin, core_out);
   endtask
   task automatic t_sample();
      ir(IR_SAMPLE_PRELOAD);
      e = cap(1'h0);
      dr(8, {24'h0, PRE});
      chk(d[7:0], e);
      chk(out_pin, core_out);
      chk(core_in, pad_in);
      chk(cb_in, bidi_pin);
   endtask
   task automatic t_extest();
      ir(IR_EXTEST);
      pins(PRE);
      repeat (4) @(negedge clk);
      chk(test_act, 1'h1);
      e = cap(1'h1);
      dr(8, {24'h0, NEWV});
      chk(d[7:0], e);
      pins(NEWV);
      @(negedge clk) pad_in = 2'h1;
      #1 chk(core_in, pad_in);
   endtask
   task automatic t_hold();
      ir(IR_CLAMP);
      pins(NEWV);
      ir(IR_AC_PIN_TEST_TRAIN);
      pins(NEWV);
      ir(IR_AC_PIN_TEST_PULSE);
      pins(NEWV);
      ir(IR_CLAMP);
      dr(2, 32'h1);
      chk(d[1:0], 2'h2);
      ir(IR_BYPASS);
      chk(out_pin, core_out);
      repeat (4) @(negedge clk);
      chk(test_act, 1'h0);
   endtask
   task automatic t_highz();
      ir(IR_HIGHZ);
      chk(out_oe_n, 2'h3);
      chk(bidi_oe_n, 2'h3);
      bsc_ctl_model_inst.tlr();
      dr(32, 32'h0);
      chk(d, ID_VALUE);
      chk(bsc_ctl_model_inst.oe_bad, 1'h0);
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'h0;
      pad_in = 2'h2;
      core_out = 2'h3;
      bidi_ext = 2'h2;
      cb_out = 2'h1;
      cb_oe = 2'h1;
      repeat (10) @(posedge clk);
      @(negedge clk) rst_n = 1'h1;
      t_reset();
      t_bypass();
      t_sample();
      t_extest();
      t_hold();
      t_highz();
      wrap_up();
   end
   initial begin
      #100000;
      n_fail++;
      wrap_up();
   end
endmodule

// ===== hdl/bsc_pkg.sv
// Constants and carrier types for the boundary-scan test port
package bsc_pkg;
   localparam int IR_W = 6;
   localparam int ID_W = 32;
   localparam int NUM_IN = 2;
   localparam int NUM_OUT = 2;
   localparam int NUM_BIDI = 2;
   localparam int CHAIN_LEN = NUM_IN + NUM_OUT + 2 * NUM_BIDI;
   localparam int OUT_BASE = NUM_IN;
   localparam int BIDI_BASE = NUM_IN + NUM_OUT;
   localparam int SYNC_W = NUM_IN + NUM_OUT + 3 * NUM_BIDI;

   localparam logic [IR_W-1:0] IR_EXTEST = 6'h00;
   localparam logic [IR_W-1:0] IR_SAMPLE_PRELOAD = 6'h01;
   localparam logic [IR_W-1:0] IR_IDCODE = 6'h02;
   localparam logic [IR_W-1:0] IR_HIGHZ = 6'h03;
   localparam logic [IR_W-1:0] IR_CAPTURE_IR_DEFAULT = 6'h2D;
   localparam logic [IR_W-1:0] IR_AC_PIN_TEST_TRAIN = 6'h3C;
   localparam logic [IR_W-1:0] IR_AC_PIN_TEST_PULSE = 6'h3D;
   localparam logic [IR_W-1:0] IR_CLAMP = 6'h3E;
   localparam logic [IR_W-1:0] IR_BYPASS = 6'h3F;

   // Identification fields; maker, part and version values are arbitrary
   localparam logic [10:0] ID_MAKER = 11'h0A5;
   localparam logic [15:0] ID_PART = 16'h1234;
   localparam logic [3:0] ID_VERSION = 4'h1;
   localparam logic ID_LSB = 1'h1;
   localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};

   localparam logic BYPASS_CAPTURE = 1'h0;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
      TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
   } bsc_tap_t;

   // Rising test clock state
   typedef struct packed {
      bsc_tap_t st;
      logic [IR_W-1:0] ir_sh;
      logic byp;
      logic [ID_W-1:0] id_sh;
      logic [CHAIN_LEN-1:0] bsr;
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
   } bsc_pos_t;

   // Falling test clock state
   typedef struct packed {
      logic [IR_W-1:0] ir_cur;
      logic [CHAIN_LEN-1:0] upd;
      logic test_act;
      logic tdo;
      logic tdo_oe_n;
   } bsc_neg_t;

   // System clock state
   typedef struct packed {
      logic [1:0] act_sync;
   } bsc_sys_t;
endpackage

// ===== hdl/bsc_tap_top.sv
// Boundary-scan test access port with boundary cells, instruction and data registers
`timescale 1ns/100ps
module bsc_tap_top import bsc_pkg::*; (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_scan_clk,
   input wire logic i_scan_rst_n,
   input wire logic i_scan_mode_sel,
   input wire logic i_scan_data_in,
   output logic o_scan_data_out,
   output logic o_scan_data_out_oe_n,
   input wire logic [NUM_IN-1:0] i_pad_in,
   output logic [NUM_IN-1:0] o_core_in,
   input wire logic [NUM_OUT-1:0] i_core_out,
   output logic [NUM_OUT-1:0] o_out_pin,
   output logic [NUM_OUT-1:0] o_out_pin_oe_n,
   input wire logic [NUM_BIDI-1:0] i_bidi_pin,
   output logic [NUM_BIDI-1:0] o_bidi_pin,
   output logic [NUM_BIDI-1:0] o_bidi_pin_oe_n,
   input wire logic [NUM_BIDI-1:0] i_core_bidi_out,
   input wire logic [NUM_BIDI-1:0] i_core_bidi_oe,
   output logic [NUM_BIDI-1:0] o_core_bidi_in,
   output logic o_core_test_active
);

   bsc_pos_t pos_r;
   bsc_pos_t pos_nxt;
   bsc_neg_t neg_r;
   bsc_neg_t neg_nxt;
   bsc_sys_t sys_r;
   bsc_sys_t sys_nxt;
   logic [CHAIN_LEN-1:0] cap_vec;
   logic [SYNC_W-1:0] raw_in;
   logic sel_bsr;
   logic sel_id;
   logic hz;
   logic [NUM_IN-1:0] s_pad;
   logic [NUM_OUT-1:0] s_core_out;
   logic [NUM_BIDI-1:0] s_bidi_pad;
   logic [NUM_BIDI-1:0] s_core_bo;
   logic [NUM_BIDI-1:0] s_core_boe;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction decode

   always_comb begin
      sel_bsr = (neg_r.ir_cur == IR_EXTEST) || (neg_r.ir_cur == IR_SAMPLE_PRELOAD) ||
         (neg_r.ir_cur == IR_AC_PIN_TEST_TRAIN) || (neg_r.ir_cur == IR_AC_PIN_TEST_PULSE);
      sel_id = (neg_r.ir_cur == IR_IDCODE);
      hz = (neg_r.ir_cur == IR_HIGHZ);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin inputs cross into the test clock domain

   assign raw_in = {i_core_bidi_oe, i_core_bidi_out, i_bidi_pin, i_core_out, i_pad_in};
   assign {s_core_boe, s_core_bo, s_bidi_pad, s_core_out, s_pad} = pos_r.s2;

   // Parallel capture values for each cell
   generate
      for (genvar i = 0; i < NUM_IN; i++) begin : g_in
         assign cap_vec[i] = s_pad[i];
         assign o_core_in[i] = i_pad_in[i];
      end
      for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
         assign cap_vec[OUT_BASE+i] = s_core_out[i];
         assign o_out_pin[i] = neg_r.test_act ? neg_r.upd[OUT_BASE+i] : i_core_out[i];
         assign o_out_pin_oe_n[i] = hz;
      end
      for (genvar b = 0; b < NUM_BIDI; b++) begin : g_bidi
         logic oe_en;
         assign cap_vec[BIDI_BASE+2*b] = s_core_boe[b];
         // Single capture register fed by a mux
         assign cap_vec[BIDI_BASE+2*b+1] = (s_core_boe[b] && !neg_r.test_act) ? s_core_bo[b]
            : s_bidi_pad[b];
         assign oe_en = hz ? 1'h0 : (neg_r.test_act ? neg_r.upd[BIDI_BASE+2*b] : i_core_bidi_oe[b]);
         assign o_bidi_pin[b] = neg_r.test_act ? neg_r.upd[BIDI_BASE+2*b+1] : i_core_bidi_out[b];
         assign o_bidi_pin_oe_n[b] = !oe_en;
         assign o_core_bidi_in[b] = i_bidi_pin[b];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Rising edge: TAP machine and shift stages

   always_comb begin
      pos_nxt = pos_r;
      pos_nxt.s1 = raw_in;
      pos_nxt.s2 = pos_r.s1;
      unique case (pos_r.st)
         TAP_RESET: pos_nxt.st = i_scan_mode_sel ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: pos_nxt.st = i_scan_mode_sel ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: pos_nxt.st = i_scan_mode_sel ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: pos_nxt.st = i_scan_mode_sel ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: pos_nxt.st = i_scan_mode_sel ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: pos_nxt.st = i_scan_mode_sel ? TAP_UPD_DR : TAP_PA_DR;
         TAP_PA_DR: pos_nxt.st = i_scan_mode_sel ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: pos_nxt.st = i_scan_mode_sel ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: pos_nxt.st = i_scan_mode_sel ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: pos_nxt.st = i_scan_mode_sel ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: pos_nxt.st = i_scan_mode_sel ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: pos_nxt.st = i_scan_mode_sel ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: pos_nxt.st = i_scan_mode_sel ? TAP_UPD_IR : TAP_PA_IR;
         TAP_PA_IR: pos_nxt.st = i_scan_mode_sel ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: pos_nxt.st = i_scan_mode_sel ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: pos_nxt.st = i_scan_mode_sel ? TAP_SEL_DR : TAP_IDLE;
      endcase
      if (pos_r.st == TAP_CAP_IR) begin
         pos_nxt.ir_sh = IR_CAPTURE_IR_DEFAULT;
      end else if (pos_r.st == TAP_SH_IR) begin
         pos_nxt.ir_sh = {i_scan_data_in, pos_r.ir_sh[IR_W-1:1]};
      end
      // All data registers take the common serial input; only the selected one shifts, and bypass captures zero on every Capture-DR
      if (pos_r.st == TAP_CAP_DR) begin
         pos_nxt.byp = BYPASS_CAPTURE;
         if (sel_id) begin
            pos_nxt.id_sh = ID_VALUE;
         end
         if (sel_bsr) begin
            pos_nxt.bsr = cap_vec;
         end
      end else if (pos_r.st == TAP_SH_DR) begin
         if (sel_bsr) begin
            pos_nxt.bsr = {i_scan_data_in, pos_r.bsr[CHAIN_LEN-1:1]};
         end else if (sel_id) begin
            pos_nxt.id_sh = {i_scan_data_in, pos_r.id_sh[ID_W-1:1]};
         end else begin
            pos_nxt.byp = i_scan_data_in;
         end
      end
   end

   always_ff @(posedge i_scan_clk) begin
      if (!i_scan_rst_n) begin
         pos_r <= '{st: TAP_RESET, ir_sh: IR_IDCODE, byp: BYPASS_CAPTURE, id_sh: ID_VALUE, default: '0};
      end else begin
         pos_r <= pos_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Falling edge: current instruction, update latches, serial output

   always_comb begin
      neg_nxt = neg_r;
      if (pos_r.st == TAP_RESET) begin
         neg_nxt.ir_cur = IR_IDCODE;
      end else if (pos_r.st == TAP_UPD_IR) begin
         neg_nxt.ir_cur = pos_r.ir_sh;
      end
      // Reserved codes fall to bypass with system pins untouched
      neg_nxt.test_act = (neg_nxt.ir_cur == IR_EXTEST) || (neg_nxt.ir_cur == IR_CLAMP) ||
         (neg_nxt.ir_cur == IR_AC_PIN_TEST_TRAIN) || (neg_nxt.ir_cur == IR_AC_PIN_TEST_PULSE);
      if (pos_r.st == TAP_UPD_DR && sel_bsr) begin
         neg_nxt.upd = pos_r.bsr;
      end
      neg_nxt.tdo_oe_n = !(pos_r.st == TAP_SH_DR || pos_r.st == TAP_SH_IR);
      if (pos_r.st == TAP_SH_IR) begin
         neg_nxt.tdo = pos_r.ir_sh[0];
      end else if (pos_r.st == TAP_SH_DR) begin
         neg_nxt.tdo = sel_bsr ? pos_r.bsr[0] : (sel_id ? pos_r.id_sh[0] : pos_r.byp);
      end else begin
         neg_nxt.tdo = 1'h0;
      end
   end

   // Falling-edge latching keeps test clock skew from corrupting cell data
   always_ff @(negedge i_scan_clk) begin
      if (!i_scan_rst_n) begin
         neg_r <= '{ir_cur: IR_IDCODE, tdo_oe_n: 1'h1, default: '0};
      end else begin
         neg_r <= neg_nxt;
      end
   end

   assign o_scan_data_out = neg_r.tdo;
   assign o_scan_data_out_oe_n = neg_r.tdo_oe_n;

   ////////////////////////////////////////////////////////////////////////////
   // Test-active level into the system clock domain

   always_comb begin
      sys_nxt.act_sync = {sys_r.act_sync[0], neg_r.test_act};
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sys_r <= '0;
      end else begin
         sys_r <= sys_nxt;
      end
   end

   assign o_core_test_active = sys_r.act_sync[1];

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_five_ones_reset;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      i_scan_mode_sel [*5] |=> pos_r.st == TAP_RESET;
   endproperty
   a_five_ones_reset: assert property (p_five_ones_reset) else $error("TAP not reset by mode select");

   property p_capture_ir;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_CAP_IR |=> pos_r.ir_sh == IR_CAPTURE_IR_DEFAULT;
   endproperty
   a_capture_ir: assert property (p_capture_ir) else $error("Capture-IR value wrong");

   property p_bypass_zero;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_CAP_DR |=> pos_r.byp == 1'h0;
   endproperty
   a_bypass_zero: assert property (p_bypass_zero) else $error("Bypass did not capture zero");

   property p_ir_hold;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st != TAP_UPD_IR && pos_r.st != TAP_RESET |-> $stable(neg_r.ir_cur);
   endproperty
   a_ir_hold: assert property (p_ir_hold) else $error("Instruction changed outside Update-IR");

   property p_ir_update;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_UPD_IR |=> neg_r.ir_cur == $past(pos_r.ir_sh);
   endproperty
   a_ir_update: assert property (p_ir_update) else $error("Update-IR did not load instruction");

   property p_reset_idcode;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_RESET |=> neg_r.ir_cur == IR_IDCODE;
   endproperty
   a_reset_idcode: assert property (p_reset_idcode) else $error("Reset did not select identification");

   property p_highz;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      neg_r.ir_cur == IR_HIGHZ |-> (&o_out_pin_oe_n) && (&o_bidi_pin_oe_n);
   endproperty
   a_highz: assert property (p_highz) else $error("Driver enabled under high impedance");

   property p_extest_drive;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      neg_r.ir_cur == IR_EXTEST |-> o_out_pin == neg_r.upd[OUT_BASE +: NUM_OUT];
   endproperty
   a_extest_drive: assert property (p_extest_drive) else $error("Pins not at latch values");

   property p_update_dr;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_UPD_DR && sel_bsr |=> neg_r.upd == $past(pos_r.bsr);
   endproperty
   a_update_dr: assert property (p_update_dr) else $error("Update-DR did not load latches");

   property p_id_lsb;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_CAP_DR && sel_id |=> pos_r.id_sh[0] == 1'h1 ##1 pos_r.id_sh[0] == 1'h1;
   endproperty
   a_id_lsb: assert property (p_id_lsb) else $error("Identification bit 0 not one");

   property p_observe_only;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      sel_bsr |-> o_core_in == i_pad_in;
   endproperty
   a_observe_only: assert property (p_observe_only) else $error("Input cell drove core");

   // Serial output: driven only in the shift states, from the selected register
   property p_tdo_idle;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st != TAP_SH_DR && pos_r.st != TAP_SH_IR |-> o_scan_data_out_oe_n && !o_scan_data_out;
   endproperty
   a_tdo_idle: assert property (p_tdo_idle) else $error("Serial output active outside shift");

   property p_tdo_ir;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_SH_IR |-> !o_scan_data_out_oe_n && o_scan_data_out == pos_r.ir_sh[0];
   endproperty
   a_tdo_ir: assert property (p_tdo_ir) else $error("Instruction bit not on serial output");

   property p_tdo_bsr;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_SH_DR && sel_bsr |-> !o_scan_data_out_oe_n && o_scan_data_out == pos_r.bsr[0];
   endproperty
   a_tdo_bsr: assert property (p_tdo_bsr) else $error("Boundary bit not on serial output");

   property p_tdo_bypass;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_SH_DR && !sel_bsr && !sel_id |-> o_scan_data_out == pos_r.byp;
   endproperty
   a_tdo_bypass: assert property (p_tdo_bypass) else $error("Bypass bit not on serial output");

   // Shift stages take the common serial input at their head
   property p_ir_shift;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_SH_IR |=> pos_r.ir_sh[IR_W-1] == $past(i_scan_data_in);
   endproperty
   a_ir_shift: assert property (p_ir_shift) else $error("Instruction stage did not shift");

   property p_bsr_shift;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_SH_DR && sel_bsr |=> pos_r.bsr[CHAIN_LEN-1] == $past(i_scan_data_in);
   endproperty
   a_bsr_shift: assert property (p_bsr_shift) else $error("Boundary chain did not shift");

   property p_bypass_shift;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_SH_DR && !sel_bsr && !sel_id |=> pos_r.byp == $past(i_scan_data_in);
   endproperty
   a_bypass_shift: assert property (p_bypass_shift) else $error("Bypass bit did not shift");

   // Bidirectional capture mux: core data when enabled and not under test, else pad
   property p_cap_core;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_CAP_DR && sel_bsr && !neg_r.test_act && s_core_boe[0] |=>
         pos_r.bsr[BIDI_BASE+1] == $past(s_core_bo[0]);
   endproperty
   a_cap_core: assert property (p_cap_core) else $error("Capture cell missed core data");

   property p_cap_pad;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_CAP_DR && sel_bsr && (neg_r.test_act || !s_core_boe[1]) |=>
         pos_r.bsr[BIDI_BASE+3] == $past(s_bidi_pad[1]);
   endproperty
   a_cap_pad: assert property (p_cap_pad) else $error("Capture cell missed pad data");

   property p_clamp;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      neg_r.ir_cur == IR_CLAMP |-> !sel_bsr && !sel_id && o_out_pin == neg_r.upd[OUT_BASE +: NUM_OUT];
   endproperty
   a_clamp: assert property (p_clamp) else $error("Clamp not holding pins with bypass");

   property p_extest_now;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      pos_r.st == TAP_UPD_IR && pos_r.ir_sh == IR_EXTEST |-> neg_r.test_act &&
         o_out_pin == neg_r.upd[OUT_BASE +: NUM_OUT];
   endproperty
   a_extest_now: assert property (p_extest_now) else $error("Latch values not driven at Update-IR");

   property p_follow_core;
      @(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      !neg_r.test_act |-> o_out_pin == i_core_out;
   endproperty
   a_follow_core: assert property (p_follow_core) else $error("Pins not following core");

   // Test-active level reaches the system side within the synchroniser delay
   property p_sys_sync;
      @(posedge i_clk) disable iff (!i_rst_n)
      neg_r.test_act |-> ##[1:3] o_core_test_active;
   endproperty
   a_sys_sync: assert property (p_sys_sync) else $error("Test-active level not synchronised");

   c_extest: cover property (@(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      neg_r.ir_cur == IR_EXTEST && pos_r.st == TAP_UPD_DR);
   c_id_shift: cover property (@(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      sel_id && pos_r.st == TAP_SH_DR);
   c_clamp: cover property (@(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      neg_r.ir_cur == IR_CLAMP && pos_r.st == TAP_SH_DR);
   c_sample: cover property (@(posedge i_scan_clk) disable iff (!i_scan_rst_n)
      neg_r.ir_cur == IR_SAMPLE_PRELOAD && pos_r.st == TAP_CAP_DR);

endmodule
